/* bfi_filter.v */
// Binaural left/right filtering with coefficient and gain interpolation.
// Assumes upstream delivers one load per subframe on this clock, with
// filters already time-difference adjusted, and samples at audio rate.
//
// Notes on behaviour
// - On direction change, interpolation count is angle measure, clamped to 12.
// - Angle measure is max of azimuth and elevation change magnitudes times 100.
// - Coefficient steps (new-prev)/count only when count>0 and update flag set.
// - Filters are accepted only after time-difference adjustment is applied.
// - Each channel output is input convolved with current filter times gain.
// - Below the count, coefficients step linearly from previous toward new.
// - Gain ramps per sample by (new-prev gain) over the subframe length.
// - A subframe is 240 samples, 5 ms at 48 kHz.
`timescale 1ns/1ps
`include "bfi_map.vh"

module bfi_filter (
    // Clock and reset
    input  wire                          clk,
    input  wire                          nrst,
    // Subframe parameters from upstream
    input  wire                          sf_load,
    input  wire                          sf_update,
    input  wire                          itd_done,
    input  wire [`BFI_AW-1:0]            azimuth,
    input  wire [`BFI_AW-1:0]            elevation,
    input  wire [`BFI_TAPS*`BFI_CW-1:0]  filt_l,
    input  wire [`BFI_TAPS*`BFI_CW-1:0]  filt_r,
    input  wire [`BFI_GW-1:0]            gain,
    // Audio in
    input  wire                          in_valid,
    input  wire [`BFI_SW-1:0]            in_sample,
    // Audio out
    output reg                           out_valid,
    output reg  [`BFI_SW-1:0]            out_left,
    output reg  [`BFI_SW-1:0]            out_right,
    output reg  [3:0]                    interp_cnt
);

    localparam ST_WAIT = 2'b01;
    localparam ST_RUN  = 2'b10;
    localparam AW = `BFI_CW + `BFI_CFRAC + 1;
    localparam GA = `BFI_GW + `BFI_GACC_SH + 1;
    localparam [31:0] SFL = `BFI_SF_LEN;

    // Magnitude of an angle change scaled by 100
    function [23:0] ang_meas;
        input [`BFI_AW-1:0] a;
        input [`BFI_AW-1:0] b;
        reg signed [`BFI_AW:0] d;
        reg [`BFI_AW:0] m;
        begin
            d = $signed({a[`BFI_AW-1], a}) - $signed({b[`BFI_AW-1], b});
            m = d[`BFI_AW] ? (~d + 1'b1) : d;
            ang_meas = {{(24-`BFI_AW-1){1'b0}}, m} * 24'd`BFI_ANG_SCALE;
        end
    endfunction

    // Per-sample step of one coefficient, with fraction bits
    function signed [AW-1:0] coef_step;
        input [`BFI_CW-1:0] nw;
        input [`BFI_CW-1:0] pv;
        input [3:0]         cnt;
        reg signed [AW-1:0] d;
        reg signed [AW-1:0] c;
        begin
            d = ($signed({nw[`BFI_CW-1], nw})
                - $signed({pv[`BFI_CW-1], pv})) <<< `BFI_CFRAC;
            c = $signed({{(AW-4){1'b0}}, cnt});
            coef_step = d / c;
        end
    endfunction

    // Scale a filtered value by gain and saturate to a sample
    function [`BFI_SW-1:0] apply_gain;
        input signed [`BFI_MACW-1:0] conv;
        input [`BFI_GW-1:0]          g;
        reg signed [`BFI_MACW-1:0]   c;
        reg signed [`BFI_MACW+`BFI_GW:0] p;
        begin
            c = conv >>> `BFI_COEF_SH;
            p = (c * $signed({1'b0, g})) >>> `BFI_GAIN_SH;
            if (p > $signed(17'sh07FFF))
                apply_gain = 16'h7FFF;
            else if (p < $signed(-17'sh08000))
                apply_gain = 16'h8000;
            else
                apply_gain = p[`BFI_SW-1:0];
        end
    endfunction

    reg  [1:0]             state_q;
    reg  [`BFI_AW-1:0]     azim_q;
    reg  [`BFI_AW-1:0]     elev_q;
    reg  [`BFI_CW-1:0]     tgt_l_q  [0:`BFI_TAPS-1];
    reg  [`BFI_CW-1:0]     tgt_r_q  [0:`BFI_TAPS-1];
    reg  signed [AW-1:0]   acc_l_q  [0:`BFI_TAPS-1];
    reg  signed [AW-1:0]   acc_r_q  [0:`BFI_TAPS-1];
    reg  signed [AW-1:0]   stp_l_q  [0:`BFI_TAPS-1];
    reg  signed [AW-1:0]   stp_r_q  [0:`BFI_TAPS-1];
    reg  [3:0]             n_q;
    reg  [7:0]             sf_idx_q;
    reg  [`BFI_GW-1:0]     gain_new_q;
    reg  signed [GA-1:0]   gacc_q;
    reg  signed [GA-1:0]   gstep_q;
    reg  [`BFI_TAPS*`BFI_SW-1:0] hist_q;

    wire [`BFI_TAPS*`BFI_SW-1:0] hist_d;
    reg  [`BFI_TAPS*`BFI_CW-1:0] coef_l;
    reg  [`BFI_TAPS*`BFI_CW-1:0] coef_r;
    wire signed [`BFI_MACW-1:0]  conv_l;
    wire signed [`BFI_MACW-1:0]  conv_r;
    wire [23:0]  d_az;
    wire [23:0]  d_el;
    wire [23:0]  d_ang;
    wire [3:0]   cnt_d;
    wire         load;
    wire         run;
    wire [`BFI_GW-1:0] gain_cur;
    integer i;
    integer j;

    assign load  = sf_load & itd_done;
    assign run   = state_q == ST_RUN;
    assign d_az  = ang_meas(azimuth, azim_q);
    assign d_el  = ang_meas(elevation, elev_q);
    assign d_ang = (d_az > d_el) ? d_az : d_el;
    assign cnt_d = (d_ang < 24'd`BFI_CNT_MAX) ? d_ang[3:0]
                 : 4'd`BFI_CNT_MAX;
    assign hist_d = {hist_q[(`BFI_TAPS-1)*`BFI_SW-1:0], in_sample};
    assign gain_cur = gacc_q[`BFI_GACC_SH +: `BFI_GW];

    // Integer part of each interpolated coefficient feeds the MACs
    always @* begin
        coef_l = {(`BFI_TAPS*`BFI_CW){1'b0}};
        coef_r = {(`BFI_TAPS*`BFI_CW){1'b0}};
        for (j = 0; j < `BFI_TAPS; j = j + 1) begin
            coef_l[j*`BFI_CW +: `BFI_CW] = acc_l_q[j][`BFI_CFRAC +: `BFI_CW];
            coef_r[j*`BFI_CW +: `BFI_CW] = acc_r_q[j][`BFI_CFRAC +: `BFI_CW];
        end
    end

    bfi_tap_mac u_mac_l (
        .hist (hist_d),
        .coef (coef_l),
        .sum  (conv_l)
    );

    bfi_tap_mac u_mac_r (
        .hist (hist_d),
        .coef (coef_r),
        .sum  (conv_r)
    );

    always @(posedge clk) begin
        if (!nrst) begin
            state_q    <= ST_WAIT;
            azim_q     <= `BFI_RST_ANG;
            elev_q     <= `BFI_RST_ANG;
            n_q        <= 4'h0;
            interp_cnt <= 4'h0;
            sf_idx_q   <= 8'h00;
            gain_new_q <= `BFI_RST_GAIN;
            gacc_q     <= {GA{1'b0}};
            gstep_q    <= {GA{1'b0}};
            hist_q     <= {(`BFI_TAPS*`BFI_SW){1'b0}};
            out_valid  <= 1'b0;
            out_left   <= `BFI_RST_SMP;
            out_right  <= `BFI_RST_SMP;
            for (i = 0; i < `BFI_TAPS; i = i + 1) begin
                tgt_l_q[i] <= {`BFI_CW{1'b0}};
                tgt_r_q[i] <= {`BFI_CW{1'b0}};
                acc_l_q[i] <= {AW{1'b0}};
                acc_r_q[i] <= {AW{1'b0}};
                stp_l_q[i] <= {AW{1'b0}};
                stp_r_q[i] <= {AW{1'b0}};
            end
        end else begin
            out_valid <= 1'b0;
            case (state_q)
                ST_WAIT: begin
                    if (load)
                        state_q <= ST_RUN;
                end
                ST_RUN: begin
                    state_q <= ST_RUN;
                end
                default: begin
                    state_q <= ST_WAIT;
                end
            endcase
            if (load) begin
                // A load takes priority over a sample in the same cycle
                azim_q     <= azimuth;
                elev_q     <= elevation;
                n_q        <= 4'h0;
                sf_idx_q   <= 8'h00;
                gain_new_q <= gain;
                gstep_q    <= ($signed({1'b0, gain, {`BFI_GACC_SH{1'b0}}})
                             - $signed({1'b0, gain_new_q,
                                        {`BFI_GACC_SH{1'b0}}}))
                             / $signed(`BFI_SF_LEN);
                gacc_q     <= $signed({1'b0, gain_new_q,
                                       {`BFI_GACC_SH{1'b0}}});
                // Count follows the angle change even without an update
                interp_cnt <= cnt_d;
                if (cnt_d != 4'h0 && sf_update) begin
                    for (i = 0; i < `BFI_TAPS; i = i + 1) begin
                        stp_l_q[i] <= coef_step(filt_l[i*`BFI_CW +: `BFI_CW],
                                                tgt_l_q[i], cnt_d);
                        stp_r_q[i] <= coef_step(filt_r[i*`BFI_CW +: `BFI_CW],
                                                tgt_r_q[i], cnt_d);
                        acc_l_q[i] <= $signed({tgt_l_q[i][`BFI_CW-1],
                            tgt_l_q[i], {`BFI_CFRAC{1'b0}}});
                        acc_r_q[i] <= $signed({tgt_r_q[i][`BFI_CW-1],
                            tgt_r_q[i], {`BFI_CFRAC{1'b0}}});
                    end
                end else begin
                    // No interpolation: jump straight to the new filter;
                    // zero steps so stale ones cannot drift it
                    for (i = 0; i < `BFI_TAPS; i = i + 1) begin
                        stp_l_q[i] <= {AW{1'b0}};
                        stp_r_q[i] <= {AW{1'b0}};
                        acc_l_q[i] <= $signed({filt_l[i*`BFI_CW+`BFI_CW-1],
                            filt_l[i*`BFI_CW +: `BFI_CW], {`BFI_CFRAC{1'b0}}});
                        acc_r_q[i] <= $signed({filt_r[i*`BFI_CW+`BFI_CW-1],
                            filt_r[i*`BFI_CW +: `BFI_CW], {`BFI_CFRAC{1'b0}}});
                    end
                end
                for (i = 0; i < `BFI_TAPS; i = i + 1) begin
                    tgt_l_q[i] <= filt_l[i*`BFI_CW +: `BFI_CW];
                    tgt_r_q[i] <= filt_r[i*`BFI_CW +: `BFI_CW];
                end
            end else if (in_valid && run) begin
                hist_q    <= hist_d;
                out_valid <= 1'b1;
                out_left  <= apply_gain(conv_l, gain_cur);
                out_right <= apply_gain(conv_r, gain_cur);
                if (n_q + 4'h1 < interp_cnt) begin
                    n_q <= n_q + 4'h1;
                    for (i = 0; i < `BFI_TAPS; i = i + 1) begin
                        acc_l_q[i] <= acc_l_q[i] + stp_l_q[i];
                        acc_r_q[i] <= acc_r_q[i] + stp_r_q[i];
                    end
                end else begin
                    // Snap exactly to target; division residue is dropped
                    n_q <= interp_cnt;
                    for (i = 0; i < `BFI_TAPS; i = i + 1) begin
                        acc_l_q[i] <= $signed({tgt_l_q[i][`BFI_CW-1],
                            tgt_l_q[i], {`BFI_CFRAC{1'b0}}});
                        acc_r_q[i] <= $signed({tgt_r_q[i][`BFI_CW-1],
                            tgt_r_q[i], {`BFI_CFRAC{1'b0}}});
                    end
                end
                if (sf_idx_q + 8'h01 < `BFI_SF_LEN) begin
                    sf_idx_q <= sf_idx_q + 8'h01;
                    gacc_q   <= gacc_q + gstep_q;
                end else begin
                    // Past the subframe the gain holds at its target
                    sf_idx_q <= SFL[7:0];
                    gacc_q   <= $signed({1'b0, gain_new_q,
                                         {`BFI_GACC_SH{1'b0}}});
                end
            end
        end
    end

endmodule

/* bfi_map.vh */
// Constants for the binaural filter interpolation stage.
// Included by every design file of the block; definitions only.
`ifndef BFI_MAP_VH
`define BFI_MAP_VH

// Data shapes
`define BFI_TAPS       8
`define BFI_SW         16
`define BFI_CW         16
`define BFI_GW         16
`define BFI_AW         16
`define BFI_MACW       35

// Fixed-point positions
`define BFI_CFRAC      8
`define BFI_COEF_SH    15
`define BFI_GAIN_SH    14
`define BFI_GACC_SH    16

// Subframe timing: 5 ms at 48 kHz
`define BFI_SF_MS      5
`define BFI_FS_KHZ     48
`define BFI_SF_LEN     (`BFI_SF_MS * `BFI_FS_KHZ)

// Direction-change interpolation
`define BFI_CNT_MAX    12
`define BFI_ANG_SCALE  100

// Reset values
`define BFI_RST_ANG    16'h0000
`define BFI_RST_GAIN   16'h0000
`define BFI_RST_SMP    16'h0000

`endif

/* bfi_tap_mac.v */
// Dot product of a sample history with one channel's filter taps.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "bfi_map.vh"

module bfi_tap_mac (
    // Operands, tap 0 in the low bits
    input  wire [`BFI_TAPS*`BFI_SW-1:0] hist,
    input  wire [`BFI_TAPS*`BFI_CW-1:0] coef,
    // Result
    output reg  signed [`BFI_MACW-1:0]  sum
);

    integer i;
    reg signed [`BFI_SW+`BFI_CW-1:0] prod;

    always @* begin
        sum  = {`BFI_MACW{1'b0}};
        prod = {(`BFI_SW+`BFI_CW){1'b0}};
        for (i = 0; i < `BFI_TAPS; i = i + 1) begin
            prod = $signed(hist[i*`BFI_SW +: `BFI_SW])
                 * $signed(coef[i*`BFI_CW +: `BFI_CW]);
            sum  = sum + {{(`BFI_MACW-`BFI_SW-`BFI_CW){prod[`BFI_SW+`BFI_CW-1]}},
                          prod};
        end
    end

endmodule

/* bfi_upstream_model.sv */
// Upstream model: delivers filter pairs with their time-difference flag, angles
// and gain as one-cycle loads. Assumes the bench calls load hierarchically.
`timescale 1ns/1ps

module bfi_upstream_model (
    // Clock
    input  wire         clk,
    // Subframe parameters towards the filter
    output reg          sf_load,
    output reg          sf_update,
    output reg          itd_done,
    output reg  [15:0]  azimuth,
    output reg  [15:0]  elevation,
    output reg  [127:0] filt_l,
    output reg  [127:0] filt_r,
    output reg  [15:0]  gain
);
    initial {sf_load, sf_update, itd_done, azimuth, elevation} = 0;
    initial {filt_l, filt_r, gain} = 0;

    // One-tap filters keep the expected sums exact
    task load(input [15:0] az, el, tl, tr, g, input upd, ok);
        begin
            @(posedge clk);
            sf_load   <= 1'b1;
            sf_update <= upd;
            itd_done  <= ok;
            azimuth   <= az;
            elevation <= el;
            filt_l    <= {112'h0, tl};
            filt_r    <= {112'h0, tr};
            gain      <= g;
            @(posedge clk);
            sf_load   <= 1'b0;
            // Fields are stale after the load; never show the last value
            {sf_update, itd_done} <= ~{upd, ok};
            {azimuth, elevation, gain} <= ~{az, el, g};
            {filt_l, filt_r} <= ~{filt_l, filt_r};
            #1;
        end
    endtask
endmodule

/* bfi_filter_chk.sv */
// Concurrent checks on the binaural filter ports.
// Bound into every bfi_filter instance by the statement at the foot.
`timescale 1ns/1ps

module bfi_filter_chk (
    // Clock and reset
    input wire         clk,
    input wire         nrst,
    // Subframe parameters
    input wire         sf_load,
    input wire         sf_update,
    input wire         itd_done,
    input wire [15:0]  azimuth,
    input wire [15:0]  elevation,
    input wire [127:0] filt_l,
    input wire [127:0] filt_r,
    input wire [15:0]  gain,
    // Audio
    input wire         in_valid,
    input wire [15:0]  in_sample,
    input wire         out_valid,
    input wire [15:0]  out_left,
    input wire [15:0]  out_right,
    input wire [3:0]   interp_cnt
);
    reg  [15:0] az_q;
    reg  [15:0] el_q;
    reg         run_q;
    wire        acc = sf_load && itd_done;

    // Angles of the last accepted load
    always @(posedge clk) begin
        if (!nrst) begin
            az_q  <= 16'h0000;
            el_q  <= 16'h0000;
            run_q <= 1'b0;
        end else if (acc) begin
            az_q  <= azimuth;
            el_q  <= elevation;
            run_q <= 1'b1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_cnt_range: assert property (interp_cnt <= 4'hC)
        else $error("interp count above twelve");
    a_cnt_same: assert property (acc && azimuth == az_q && elevation == el_q
        |=> interp_cnt == 4'h0) else $error("count set without change");
    a_cnt_change: assert property (acc && (azimuth != az_q ||
        elevation != el_q) |=> interp_cnt == 4'hC) else $error("count not 12");
    a_cnt_hold: assert property (!acc |=> $stable(interp_cnt))
        else $error("count moved without load");
    a_refused_load: assert property (sf_load && !itd_done
        |=> $stable(interp_cnt)) else $error("unadjusted load taken");
    a_out_pulse: assert property (in_valid && !acc && run_q |=> out_valid)
        else $error("sample gave no output");
    a_no_out: assert property (!(in_valid && !acc && run_q) |=> !out_valid)
        else $error("output without sample");
    a_out_hold: assert property (!out_valid |->
        $stable(out_left) && $stable(out_right)) else $error("output moved");
endmodule

bind bfi_filter bfi_filter_chk u_chk (.clk(clk), .nrst(nrst),
    .sf_load(sf_load), .sf_update(sf_update), .itd_done(itd_done),
    .azimuth(azimuth), .elevation(elevation), .filt_l(filt_l),
    .filt_r(filt_r), .gain(gain), .in_valid(in_valid),
    .in_sample(in_sample), .out_valid(out_valid), .out_left(out_left),
    .out_right(out_right), .interp_cnt(interp_cnt));

/* bfi_filter_test.sv */
// Self-checking bench for bfi_filter with the upstream model.
// Input held at 16'h1000 except one 16'h2000 sample, and one-tap filters make every output exactly known.
`timescale 1ns/1ps

module bfi_filter_test;
    reg          clk = 1'b0;
    reg          nrst = 1'b0;
    reg          in_valid = 1'b0;
    reg  [15:0]  in_sample = 16'h1000;
    wire         sf_load;
    wire         sf_update;
    wire         itd_done;
    wire [15:0]  azimuth;
    wire [15:0]  elevation;
    wire [15:0]  gain;
    wire [127:0] filt_l;
    wire [127:0] filt_r;
    wire         out_valid;
    wire [15:0]  out_left;
    wire [15:0]  out_right;
    wire [3:0]   interp_cnt;
    integer      err_total = 0;
    integer      comparisons = 0;

    always #10 clk = ~clk;

    bfi_upstream_model u_up (.clk(clk), .sf_load(sf_load),
        .sf_update(sf_update), .itd_done(itd_done), .azimuth(azimuth),
        .elevation(elevation), .filt_l(filt_l), .filt_r(filt_r), .gain(gain));

    bfi_filter u_dut (.clk(clk), .nrst(nrst), .sf_load(sf_load),
        .sf_update(sf_update), .itd_done(itd_done), .azimuth(azimuth),
        .elevation(elevation), .filt_l(filt_l), .filt_r(filt_r), .gain(gain),
        .in_valid(in_valid), .in_sample(in_sample), .out_valid(out_valid),
        .out_left(out_left), .out_right(out_right), .interp_cnt(interp_cnt));

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task tally_and_finish;
        begin
            $display("Comparisons %0d mismatches %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // One sample; output is due exactly one cycle after acceptance
    task smp(input logic v, input logic [15:0] el, input logic [15:0] er);
        begin
            @(posedge clk);
            in_valid <= 1'b1;
            @(posedge clk);
            in_valid <= 1'b0;
            #1;
            chk({15'h0, out_valid}, {15'h0, v});
            if (v) begin
                chk(out_left, el);
                chk(out_right, er);
            end
        end
    endtask

    task t_idle;
        begin
            repeat (3) smp(1'b0, 16'h0, 16'h0);
            chk({12'h0, interp_cnt}, 16'h0000);
        end
    endtask

    // Gain climbs from zero to unity over one subframe, then holds
    task t_gain_ramp;
        integer     k;
        logic [63:0] g;
        begin
            u_up.load(16'h0, 16'h0, 16'h4000, 16'h2000, 16'h4000, 1'b1, 1'b1);
            chk({12'h0, interp_cnt}, 16'h0000);
            for (k = 0; k < 242; k = k + 1) begin
                g = (k < 240) ? ((k * ((64'h4000 << 16) / 240)) >> 16) : 64'h4000;
                smp(1'b1, g[18:3], g[19:4]);
            end
        end
    endtask

    task t_coef_ramp;
        integer k;
        integer e;
        begin
            u_up.load(16'h1, 16'h0, 16'h1000, 16'h2000, 16'h4000, 1'b1, 1'b1);
            chk({12'h0, interp_cnt}, 16'h000C);
            for (k = 0; k < 14; k = k + 1) begin
                e = (k < 12) ? (16384 - 1024 * k) / 8 : 512;
                smp(1'b1, e[15:0], 16'h0400);
            end
        end
    endtask

    task t_jump;
        begin
            u_up.load(16'h1, 16'hFFFE, 16'h4000, 16'h2000, 16'h4000, 1'b0, 1'b1);
            chk({12'h0, interp_cnt}, 16'h000C);
            repeat (2) smp(1'b1, 16'h0800, 16'h0400);
        end
    endtask

    task t_same;
        begin
            u_up.load(16'h1, 16'hFFFE, 16'h1000, 16'h2000, 16'h4000, 1'b1, 1'b1);
            chk({12'h0, interp_cnt}, 16'h0000);
            smp(1'b1, 16'h0200, 16'h0400);
            @(posedge clk);
            in_sample <= 16'h2000;
            smp(1'b1, 16'h0400, 16'h0800);
            @(posedge clk);
            in_sample <= 16'h1000;
        end
    endtask

    // Mid-run reset: outputs cleared, samples ignored until a load
    task t_reset;
        begin
            @(posedge clk);
            nrst <= 1'b0;
            repeat (2) @(posedge clk);
            nrst <= 1'b1;
            #1;
            chk(out_left, 16'h0000);
            chk(out_right, 16'h0000);
            chk({12'h0, interp_cnt}, 16'h0000);
            smp(1'b0, 16'h0, 16'h0);
        end
    endtask

    // Unadjusted filters must leave count and current filter untouched
    task t_refused;
        begin
            u_up.load(16'h5, 16'h0, 16'h4000, 16'h4000, 16'h4000, 1'b1, 1'b0);
            chk({12'h0, interp_cnt}, 16'h0000);
            smp(1'b1, 16'h0200, 16'h0400);
        end
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        err_total = err_total + 1;
        tally_and_finish;
    end

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_idle;
        t_gain_ramp;
        t_coef_ramp;
        t_jump;
        t_same;
        t_refused;
        t_reset;
        tally_and_finish;
    end
endmodule
